// ---- hdl/overcurrent_hiccup_share_sequencer.sv ----
// overcurrent_hiccup_share_sequencer: hiccup fault sequencing and share-bus math
// assumes softstart_tick pulses once per soft-start interval end, switch_tick per cycle
module overcurrent_hiccup_share_sequencer #(
	parameter int unsigned QUAL = ocp_pkg::QUAL_CYCLES,
	parameter int unsigned INTERVALS = ocp_pkg::HICCUP_INTERVALS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic switch_tick,
	input wire logic softstart_tick,
	input wire logic in_regulation,
	input wire logic ch1_pwm,
	input wire logic ch2_pwm,
	input wire logic [ocp_pkg::CUR_W-1:0] ch1_sense_current,
	input wire logic [ocp_pkg::CUR_W-1:0] ch2_sense_current,
	input wire logic share_bus_over,
	input wire logic [ocp_pkg::CUR_W-1:0] share_set_level,
	input wire logic [ocp_pkg::CUR_W-1:0] share_bus_level,
	input wire ocp_pkg::strap_s straps,
	output logic enable_feedforward,
	output logic softstart_run,
	output logic power_good,
	output logic multiphase,
	output logic ch1_error_amp_en,
	output logic ch2_error_amp_en,
	output ocp_pkg::share_s share
);
	import ocp_pkg::*;

	// ---------------------------------------
	// sampling per channel
	// ---------------------------------------
	logic [CUR_W-1:0] ch1_sampled_current;
	logic [CUR_W-1:0] ch2_sampled_current;
	logic sampler_rst;
	// no switching while enable is low: drop stale samples so a restart re-measures
	assign sampler_rst = rst || !enable_feedforward;
	current_sampler u_s1 (
		.mclk(mclk),
		.rst(sampler_rst),
		.pwm(ch1_pwm),
		.sense_current_out(ch1_sense_current),
		.sampled_current(ch1_sampled_current),
		.sample_done()
	);
	current_sampler u_s2 (
		.mclk(mclk),
		.rst(sampler_rst),
		.pwm(ch2_pwm),
		.sense_current_out(ch2_sense_current),
		.sampled_current(ch2_sampled_current),
		.sample_done()
	);

	// ---------------------------------------
	// synchronisers and mode
	// ---------------------------------------
	logic sb_meta, sb_sync, next_sb_meta, next_sb_sync;
	strap_s st_q, next_st_q;
	always_comb begin
		next_sb_meta = share_bus_over;
		next_sb_sync = sb_meta;
		next_st_q = straps;
	end

	// ---------------------------------------
	// qualification counters
	// ---------------------------------------
	logic [1:0] ch_over;
	logic [3:0] qcnt [2];
	logic [3:0] next_qcnt [2];
	logic [1:0] ch_trip;
	localparam logic [3:0] Q4 = 4'(QUAL);

	always_comb begin
		ch_over[0] = ch1_sampled_current > CH_TRIP_NA;
		ch_over[1] = ch2_sampled_current > CH_TRIP_NA;
	end

	for (genvar i = 0; i < 2; i++) begin : g_qual
		always_comb begin
			next_qcnt[i] = qcnt[i];
			if (!ch_over[i]) begin
				next_qcnt[i] = 4'h0;
			end else if (switch_tick && qcnt[i] != Q4) begin
				next_qcnt[i] = qcnt[i] + 4'h1;
			end
		end
		always_ff @(posedge mclk) begin
			if (rst) begin
				qcnt[i] <= 4'h0;
			end else begin
				qcnt[i] <= next_qcnt[i];
			end
		end
		// dual mode lets channel 2 bypass the delay
		assign ch_trip[i] = (qcnt[i] == Q4) || (i == 1 && !multiphase && ch_over[i]);
	end

	logic oc_trip;
	// share-bus comparator always armed; in dual mode it is channel 1's fast path
	assign oc_trip = ch_trip[0] | ch_trip[1] | sb_sync;

	// ---------------------------------------
	// hiccup sequencer
	// ---------------------------------------
	seq_e state, next_state;
	logic [1:0] ivl, next_ivl;
	logic tripped_ss, next_tripped_ss;
	logic next_power_good;
	localparam logic [1:0] N2 = 2'(INTERVALS - 1);

	always_comb begin
		next_state = state;
		next_ivl = ivl;
		next_tripped_ss = tripped_ss;
		next_power_good = power_good;
		unique case (state)
			ST_SOFTSTART: begin
				next_power_good = 1'b0;
				if (oc_trip) begin
					next_tripped_ss = 1'b1;
				end
				if (softstart_tick) begin
					// interval always runs out, even after a trip
					next_tripped_ss = 1'b0;
					next_ivl = 2'h0;
					next_state = (tripped_ss || oc_trip) ? ST_WAIT : ST_RUN;
				end
			end
			ST_RUN: begin
				next_power_good = in_regulation;
				if (oc_trip) begin
					next_power_good = 1'b0;
					next_ivl = 2'h0;
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				next_power_good = 1'b0;
				if (softstart_tick) begin
					next_ivl = ivl + 2'h1;
					if (ivl == N2) begin
						next_state = ST_SOFTSTART;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_SOFTSTART;
			ivl <= 2'h0;
			tripped_ss <= 1'b0;
			power_good <= 1'b0;
			sb_meta <= 1'b0;
			sb_sync <= 1'b0;
			st_q <= '0;
		end else begin
			state <= next_state;
			ivl <= next_ivl;
			tripped_ss <= next_tripped_ss;
			power_good <= next_power_good;
			sb_meta <= next_sb_meta;
			sb_sync <= next_sb_sync;
			st_q <= next_st_q;
		end
	end

	// enable low during wait and after a soft-start trip
	assign enable_feedforward = (state != ST_WAIT) && !tripped_ss;
	assign softstart_run = (state == ST_SOFTSTART);
	assign multiphase = st_q.ch2_mode_sense_high;
	assign ch1_error_amp_en = !st_q.ch1_sense_neg_high;
	assign ch2_error_amp_en = !st_q.ch2_sense_neg_high;

	// ---------------------------------------
	// share bus and correction
	// ---------------------------------------
	share_s next_share;
	logic [CUR_W:0] sum;
	logic [CUR_W-1:0] avg_sense_current;
	always_comb begin
		sum = {1'b0, ch1_sampled_current} + {1'b0, ch2_sampled_current};
		// two_channel_average in multiphase, channel 1 copy otherwise
		avg_sense_current = multiphase ? sum[CUR_W:1] : ch1_sampled_current;
		next_share.share_bus = avg_sense_current + SHARE_OFFSET;
		next_share.share_set = avg_sense_current + SHARE_OFFSET;
		next_share.avg_en = multiphase;
		next_share.ch2_correction_en = multiphase;
		if (multiphase) begin
			next_share.ch1_correction = $signed({1'b0, ch1_sampled_current})
				- $signed({1'b0, avg_sense_current});
			next_share.ch2_correction = $signed({1'b0, ch2_sampled_current})
				- $signed({1'b0, avg_sense_current});
		end else begin
			next_share.ch1_correction = $signed({1'b0, share_set_level})
				- $signed({1'b0, share_bus_level});
			next_share.ch2_correction = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			share <= '0;
		end else begin
			share <= next_share;
		end
	end
endmodule : overcurrent_hiccup_share_sequencer

// ---- hdl/ocp_pkg.sv ----
// ocp_pkg: shared types and constants for the overcurrent hiccup sequencer
// assumes comparator outputs and sampled currents arrive as digital words on mclk
package ocp_pkg;
	localparam int unsigned MCLK_HZ = 40000000;
	localparam int unsigned CUR_W = 12;
	// trip level in nA; sampled currents are coded in nA steps
	localparam logic [CUR_W-1:0] CH_TRIP_NA = 12'h06C;
	localparam logic [CUR_W-1:0] SHARE_OFFSET = 12'h00F;
	localparam int unsigned QUAL_CYCLES = 7;
	localparam int unsigned HICCUP_INTERVALS = 3;
	localparam int unsigned BLANK_NS = 175;
	localparam int unsigned BLANK_CYC = (BLANK_NS * (MCLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned SAMPLE_CYC = BLANK_CYC;

	typedef enum logic [1:0] {
		ST_SOFTSTART,
		ST_RUN,
		ST_WAIT
	} seq_e;

	typedef struct packed {
		logic ch2_sense_neg_high;
		logic ch1_sense_neg_high;
		logic ch2_mode_sense_high;
	} strap_s;

	typedef struct packed {
		logic [CUR_W-1:0] share_bus;
		logic [CUR_W-1:0] share_set;
		logic signed [CUR_W:0] ch1_correction;
		logic signed [CUR_W:0] ch2_correction;
		logic ch2_correction_en;
		logic avg_en;
	} share_s;
endpackage : ocp_pkg

// ---- hdl/current_sampler.sv ----
// current_sampler: blank then sample one channel's sense current per pulse
// assumes pwm and sense_current_out synchronous to mclk
module current_sampler #(
	parameter int unsigned BLANK = ocp_pkg::BLANK_CYC,
	parameter int unsigned W = ocp_pkg::CUR_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic pwm,
	input wire logic [W-1:0] sense_current_out,
	output logic [W-1:0] sampled_current,
	output logic sample_done
);
	import ocp_pkg::*;
	// ---------------------------------------
	// blank and sample window
	// ---------------------------------------
	logic pwm_d, next_pwm_d;
	logic [7:0] cnt, next_cnt;
	logic [W-1:0] next_sampled_current;
	logic next_sample_done;
	localparam logic [7:0] B8 = 8'(BLANK);

	always_comb begin
		next_pwm_d = pwm;
		next_cnt = cnt;
		next_sampled_current = sampled_current;
		next_sample_done = 1'b0;
		if (pwm_d && !pwm) begin
			next_cnt = 8'h01;
		end else if (cnt != 8'h00) begin
			next_cnt = cnt + 8'h01;
			// filter: track the window, keep the last value
			if (cnt > B8) begin
				next_sampled_current = sense_current_out;
			end
			if (cnt == (B8 << 1)) begin
				next_cnt = 8'h00;
				next_sample_done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pwm_d <= 1'b0;
			cnt <= 8'h00;
			sampled_current <= '0;
			sample_done <= 1'b0;
		end else begin
			pwm_d <= next_pwm_d;
			cnt <= next_cnt;
			sampled_current <= next_sampled_current;
			sample_done <= next_sample_done;
		end
	end
endmodule : current_sampler

// ---- tb/ocp_checker.sv ----
// ocp_checker: port assertions for the hiccup sequencer
// assumes a bind to the sequencer top, one clock, sync reset
module ocp_checker #(
	parameter int unsigned INTERVALS = 3
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic softstart_tick,
	input wire logic share_bus_over,
	input wire ocp_pkg::strap_s straps,
	input wire logic enable_feedforward,
	input wire logic softstart_run,
	input wire logic power_good,
	input wire logic multiphase,
	input wire ocp_pkg::share_s share
);
	import ocp_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic wt;
	logic r1;
	logic [3:0] cnt, next_cnt;
	assign wt = !enable_feedforward && !softstart_run;
	// ticks seen in the current hiccup wait
	always_comb begin
		next_cnt = (wt && softstart_tick) ? cnt + 4'h1 : cnt;
		if (!wt) begin
			next_cnt = 4'h0;
		end
	end
	always_ff @(posedge mclk) begin
		cnt <= rst ? 4'h0 : next_cnt;
		r1 <= rst;
	end
	a_pg_off_run: assert property ((softstart_run || !enable_feedforward) |-> !power_good)
		else $error("power_good high outside run");
	a_ss_holds: assert property (softstart_run && !softstart_tick |=> softstart_run)
		else $error("soft-start cut short");
	a_ss_ends: assert property (softstart_run && softstart_tick |=> !softstart_run)
		else $error("soft-start overran its tick");
	a_wait_holds: assert property (wt && !softstart_tick |=> wt)
		else $error("wait left without tick");
	a_wait_ends: assert property (wt && softstart_tick && cnt == INTERVALS - 1
		|=> softstart_run && enable_feedforward) else $error("wait not ended after intervals");
	a_share_trip: assert property (enable_feedforward && !softstart_run && share_bus_over
		|-> ##[1:4] !enable_feedforward) else $error("share trip missed");
	a_mode_strap: assert property (!r1 |-> multiphase == $past(straps.ch2_mode_sense_high))
		else $error("mode does not follow strap");
	a_avg_mode: assert property (multiphase == $past(multiphase)
		|-> share.avg_en == multiphase && share.ch2_correction_en == multiphase)
		else $error("averaging enable wrong for mode");
	a_set_copy: assert property (share.share_set == share.share_bus)
		else $error("share_set differs from share_bus");
	c_trip: cover property (enable_feedforward && !softstart_run ##1 !enable_feedforward);
	c_ss_trip: cover property (softstart_run && $fell(enable_feedforward));
	c_wait_end: cover property (wt ##1 softstart_run);
endmodule : ocp_checker

bind overcurrent_hiccup_share_sequencer ocp_checker #(.INTERVALS(INTERVALS)) i_chk (.mclk,
	.rst, .softstart_tick, .share_bus_over, .straps, .enable_feedforward, .softstart_run,
	.power_good, .multiphase, .share);

// ---- tb/plant_model.sv ----
// plant_model: switching cycle, channel pwm and soft-start timer
// assumes bench clock and reset; pwm halts while enable is low
module plant_model #(
	parameter int PER = 40,
	parameter int SS = 400
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic enable_feedforward,
	output logic switch_tick,
	output logic softstart_tick,
	output logic ch1_pwm,
	output logic ch2_pwm
);
	int ph;
	int sc;
	always_ff @(posedge mclk) begin
		ph <= (rst || ph == PER - 1) ? 0 : ph + 1;
		sc <= (rst || sc == SS - 1) ? 0 : sc + 1;
	end
	assign switch_tick = (ph == 0);
	assign softstart_tick = (sc == SS - 1);
	// channels interleaved half a cycle apart
	assign ch1_pwm = enable_feedforward && ph < 10;
	assign ch2_pwm = enable_feedforward && ph >= 20 && ph < 30;
endmodule : plant_model

// ---- tb/overcurrent_hiccup_share_sequencer_tb.sv ----
// overcurrent_hiccup_share_sequencer_tb: self-checking bench
// assumes plant_model for ticks and pwm; bench drives currents and straps
module overcurrent_hiccup_share_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ocp_pkg::*;
	logic mclk, rst, switch_tick, softstart_tick, in_regulation, ch1_pwm, ch2_pwm;
	logic share_bus_over, enable_feedforward, softstart_run, power_good, multiphase;
	logic ch1_error_amp_en, ch2_error_amp_en;
	logic [CUR_W-1:0] ch1_sense_current, ch2_sense_current, share_set_level, share_bus_level;
	strap_s straps;
	share_s share;
	int failures, checks, seed, nt, nss;
	overcurrent_hiccup_share_sequencer i_dut (.mclk, .rst, .switch_tick, .softstart_tick,
		.in_regulation, .ch1_pwm, .ch2_pwm, .ch1_sense_current, .ch2_sense_current,
		.share_bus_over, .share_set_level, .share_bus_level, .straps, .enable_feedforward,
		.softstart_run, .power_good, .multiphase, .ch1_error_amp_en, .ch2_error_amp_en, .share);
	plant_model i_plant (.mclk, .rst, .enable_feedforward, .switch_tick, .softstart_tick,
		.ch1_pwm, .ch2_pwm);
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : cyc
	// bounded wait on enable (s=0) or soft-start (s=1), counting ticks
	task automatic wt(input int s, input logic v);
		int k;
		nt = 0;
		nss = 0;
		for (k = 0; k < 3000 && (s ? softstart_run : enable_feedforward) !== v; k++) begin
			nt += switch_tick;
			nss += softstart_tick;
			@(posedge mclk);
			#2;
		end
		chk(k < 3000, 1);
	endtask : wt
	function automatic logic [CUR_W-1:0] avg(input logic [CUR_W-1:0] a, input logic [CUR_W-1:0] b);
		logic [CUR_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[CUR_W:1];
	endfunction : avg
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#1000000;
		failures++;
		end_of_test();
	end
	initial begin
		seed = 32'he31c;
		rst = 1;
		in_regulation = 1;
		share_bus_over = 0;
		straps = 3'b001;
		ch1_sense_current = 12'h040;
		ch2_sense_current = 12'h030;
		share_set_level = 12'($random(seed));
		share_bus_level = 12'($random(seed));
		cyc(4);
		chk({enable_feedforward, softstart_run, power_good}, 3'b110);
		rst = 0;
		wt(1, 0);
		cyc(2);
		chk(power_good, 1);
		$display("test startup done");
		repeat (3) begin
			ch1_sense_current = 12'h010 + 12'($random(seed) & 12'h03F);
			ch2_sense_current = 12'h010 + 12'($random(seed) & 12'h03F);
			cyc(80);
			chk(share.share_bus, avg(ch1_sense_current, ch2_sense_current) + SHARE_OFFSET);
			chk({share.ch1_correction}, 13'({1'b0, ch1_sense_current}
				- {1'b0, avg(ch1_sense_current, ch2_sense_current)}));
		end
		$display("test share done");
		ch1_sense_current = CH_TRIP_NA;
		cyc(400);
		chk(enable_feedforward, 1);
		ch1_sense_current = CH_TRIP_NA + 12'h001 + 12'($random(seed) & 12'h00F);
		wt(0, 0);
		chk(nt >= 7 && nt <= 9, 1);
		chk(power_good, 0);
		wt(1, 1);
		chk(nss, 3);
		wt(0, 0);
		chk({softstart_run, power_good}, 2'b10);
		wt(1, 0);
		chk(enable_feedforward, 0);
		ch1_sense_current = 12'h040;
		wt(1, 1);
		wt(1, 0);
		cyc(2);
		chk(power_good, 1);
		$display("test hiccup done");
		// dual output: share bus is channel 1 alone
		straps = 3'b000;
		cyc(80);
		chk(share.share_bus, ch1_sense_current + SHARE_OFFSET);
		chk(share.ch2_correction_en, 0);
		share_bus_over = 1;
		cyc(5);
		chk(enable_feedforward, 0);
		share_bus_over = 0;
		wt(1, 1);
		wt(1, 0);
		ch2_sense_current = CH_TRIP_NA + 12'h005;
		wt(0, 0);
		chk(nt <= 2, 1);
		$display("test dual done");
		repeat (4) begin
			straps = 3'($random(seed));
			cyc(3);
			chk(ch1_error_amp_en, !straps.ch1_sense_neg_high);
			chk(ch2_error_amp_en, !straps.ch2_sense_neg_high);
			chk(multiphase, straps.ch2_mode_sense_high);
		end
		$display("test straps done");
		end_of_test();
	end
endmodule : overcurrent_hiccup_share_sequencer_tb
